// ### hw/dsb_dev_end.sv
/*
  Endpoint end of the DLLP side-band port: accepts send requests, hands DLLPs
  to the link layer, reports received DLLPs and TLPs, retry and CRC status.
  Assumes link-side ports come from logic on the same clock.
*/
`timescale 1ns/1ns
module dsb_dev_end #(
  parameter bit          HAS_AER    = 1'b1,
  parameter bit          HAS_ECRC   = 1'b1,
  parameter int unsigned RBUF_DEPTH = dsb_pkg::DSB_RBUF_DEPTH
) (
  input  wire logic                            clk_i,
  input  wire logic                            rstn_i,
  dsb_if.dev                                   sb,
  output logic                                 link_dllp_valid_o,
  output logic                                 link_dllp_is_pm_o,
  output logic [dsb_pkg::DSB_KIND_W-1:0]       link_dllp_kind_o,
  output logic [dsb_pkg::DSB_VSD_W-1:0]        link_dllp_data_o,
  input  wire logic                            link_dllp_ready_i,
  input  wire logic                            link_other_pend_i,
  input  wire logic                            link_rx_valid_i,
  input  wire logic                            link_rx_is_pm_i,
  input  wire logic [dsb_pkg::DSB_KIND_W-1:0]  link_rx_kind_i,
  input  wire logic [dsb_pkg::DSB_VSD_W-1:0]   link_rx_data_i,
  input  wire logic                            link_rx_tlp_i,
  input  wire logic                            rbuf_push_i,
  input  wire logic                            rbuf_release_i,
  output logic                                 rbuf_full_o,
  input  wire logic                            cfg_ecrc_gen_i,
  input  wire logic                            cfg_ecrc_chk_i
);
  import dsb_pkg::*;

  typedef enum logic [1:0] {
    DSB_TX_IDLE = 2'b00,
    DSB_TX_SEND = 2'b01,
    DSB_TX_HOLD = 2'b10
  } dsb_tx_state_t;

  localparam bit CRC_PORTS = HAS_AER && HAS_ECRC;

  dsb_tx_state_t           state_reg;
  dsb_tx_state_t           state_next;
  logic                    is_pm_reg;
  logic [DSB_KIND_W-1:0]   kind_reg;
  logic [DSB_VSD_W-1:0]    data_reg;
  logic                    sent_reg;
  logic [DSB_KIND_W-1:0]   rx_kind_reg;
  logic [DSB_VSD_W-1:0]    rx_vendor_reg;
  logic                    rx_pm_valid_reg;
  logic                    tlp_rcvd_reg;
  logic                    gen_en_reg;
  logic                    chk_en_reg;
  logic                    req_pm;
  logic                    req_vendor;
  logic                    accept;
  logic                    handoff;

  //////////////////////////////////////////////////////////////////////
  // Request decode
  assign req_pm     = (sb.send_sel == DSB_SEL_PM); // R1
  assign req_vendor = (sb.send_sel == DSB_SEL_VENDOR); // R2
  // None and unused select take no action
  assign accept     = (state_reg == DSB_TX_IDLE) && (req_pm || req_vendor); // R3
  assign handoff    = (state_reg == DSB_TX_SEND) && link_dllp_ready_i;

  //////////////////////////////////////////////////////////////////////
  // Transmit state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DSB_TX_IDLE: begin
        if (accept) begin
          state_next = DSB_TX_SEND;
        end
      end
      DSB_TX_SEND: begin
        if (link_dllp_ready_i) begin
          state_next = DSB_TX_HOLD;
        end
      end
      DSB_TX_HOLD: begin
        // Wait for select to drop so a held request is sent once
        if (sb.send_sel == DSB_SEL_NONE) begin
          state_next = DSB_TX_IDLE; // R17
        end
      end
      default: begin
        state_next = DSB_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= DSB_TX_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Captured request contents
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      is_pm_reg <= 1'b0;
      kind_reg  <= DSB_KIND_RST;
      data_reg  <= DSB_VSD_RST;
    end else if (accept) begin
      is_pm_reg <= req_pm; // R1
      kind_reg  <= sb.tx_kind; // R1
      data_reg  <= sb.tx_vendor; // R2
    end
  end

  assign link_dllp_valid_o = (state_reg == DSB_TX_SEND);
  assign link_dllp_is_pm_o = is_pm_reg;
  assign link_dllp_kind_o  = kind_reg;
  assign link_dllp_data_o  = data_reg;

  //////////////////////////////////////////////////////////////////////
  // Sent pulse
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sent_reg <= 1'b0;
    end else begin
      sent_reg <= handoff; // R6 R18
    end
  end

  assign sb.sent = sent_reg;

  //////////////////////////////////////////////////////////////////////
  // Pending indication
  assign sb.dllp_pending = (state_reg == DSB_TX_SEND) || link_other_pend_i; // R11

  //////////////////////////////////////////////////////////////////////
  // Received power-management DLLP
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_kind_reg     <= DSB_KIND_RST;
      rx_pm_valid_reg <= 1'b0;
    end else begin
      rx_pm_valid_reg <= link_rx_valid_i && link_rx_is_pm_i; // R9 R18
      if (link_rx_valid_i && link_rx_is_pm_i) begin
        rx_kind_reg <= link_rx_kind_i; // R7
      end
    end
  end

  assign sb.rx_kind     = rx_kind_reg;
  assign sb.rx_pm_valid = rx_pm_valid_reg;

  //////////////////////////////////////////////////////////////////////
  // Received vendor-defined DLLP
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_vendor_reg <= DSB_VSD_RST;
    end else if (link_rx_valid_i && !link_rx_is_pm_i) begin
      rx_vendor_reg <= link_rx_data_i; // R8
    end
  end

  assign sb.rx_vendor = rx_vendor_reg;

  //////////////////////////////////////////////////////////////////////
  // TLP received pulse
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tlp_rcvd_reg <= 1'b0;
    end else begin
      tlp_rcvd_reg <= link_rx_tlp_i; // R12
    end
  end

  assign sb.tlp_received = tlp_rcvd_reg;

  //////////////////////////////////////////////////////////////////////
  // Retry buffer occupancy
  dsb_rbuf_count #(
    .DEPTH     (RBUF_DEPTH)
  ) u_rbuf (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .push_i    (rbuf_push_i),
    .release_i (rbuf_release_i),
    .full_o    (rbuf_full_o),
    .empty_o   (sb.retry_empty) // R10
  );

  //////////////////////////////////////////////////////////////////////
  // End-to-end CRC status
  generate
    if (CRC_PORTS) begin : g_crc
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          gen_en_reg <= 1'b0;
          chk_en_reg <= 1'b0;
        end else begin
          gen_en_reg <= cfg_ecrc_gen_i; // R14
          chk_en_reg <= cfg_ecrc_chk_i; // R16
        end
      end
    end else begin : g_no_crc
      // Outputs absent in this configuration, held low
      assign gen_en_reg = 1'b0; // R13
      assign chk_en_reg = 1'b0; // R13
    end
  endgenerate

  assign sb.ecrc_gen_en = gen_en_reg;
  assign sb.ecrc_chk_en = chk_en_reg;
endmodule

// ### hw/dsb_pkg.sv
/*
  Shared constants and types for the DLLP side-band and end-to-end CRC status port.
  Assumes one system clock for both ends and an active-low asynchronous reset.
*/
// Contract
// R1 - Select 01 sends power-management DLLP of given kind
// R2 - Select 10 sends vendor DLLP with payload
// R3 - Select 00 idle; 11 unused, ignored
// R4 - User encodes kinds 000,001,011,100
// R5 - User supplies 24-bit vendor payload with request
// R6 - Sent indication once DLLP left link
// R7 - Received power kind reported, same encoding
// R8 - Received vendor payload presented on output
// R9 - Received-valid pulse qualifies received power kind
// R10 - High while retry buffer holds nothing
// R11 - High while any DLLP awaits transmission
// R12 - Output flags each received TLP
// R13 - CRC enable outputs only with AER and ECRC
// R14 - Generation-enabled output follows CRC generation
// R15 - User sets digest bit while generation on
// R16 - Check-enabled output follows CRC checking
// R17 - User holds request until sent, then 00
// R18 - Sent and received-valid are one-cycle pulses
package dsb_pkg;

  localparam int unsigned DSB_SEL_W     = 2;
  localparam int unsigned DSB_KIND_W    = 3;
  localparam int unsigned DSB_VSD_W     = 24;
  localparam int unsigned DSB_RBUF_DEPTH = 16;

  typedef enum logic [1:0] {
    DSB_SEL_NONE   = 2'h0,
    DSB_SEL_PM     = 2'h1,
    DSB_SEL_VENDOR = 2'h2,
    DSB_SEL_UNUSED = 2'h3
  } dsb_sel_t;

  typedef enum logic [2:0] {
    DSB_PM_ENTER_L1  = 3'h0,
    DSB_PM_ENTER_L2  = 3'h1,
    DSB_PM_ASPM_L1   = 3'h3,
    DSB_PM_REQ_ACK   = 3'h4
  } dsb_pm_kind_t;

  localparam logic [DSB_KIND_W-1:0] DSB_KIND_RST = 3'h0;
  localparam logic [DSB_VSD_W-1:0]  DSB_VSD_RST  = 24'h000000;

  // Legal kind check, used by the user end
  function automatic logic dsb_kind_legal(input logic [DSB_KIND_W-1:0] k);
    dsb_kind_legal = (k == DSB_PM_ENTER_L1) || (k == DSB_PM_ENTER_L2) ||
                     (k == DSB_PM_ASPM_L1) || (k == DSB_PM_REQ_ACK);
  endfunction

endpackage

// ### hw/dsb_if.sv
/*
  Carrier between the endpoint side-band port and user logic.
  Assumes both modports run on the same clock.
*/
`timescale 1ns/1ns
interface dsb_if;
  import dsb_pkg::*;

  dsb_sel_t                send_sel;
  logic [DSB_KIND_W-1:0]   tx_kind;
  logic [DSB_VSD_W-1:0]    tx_vendor;
  logic                    sent;
  logic [DSB_KIND_W-1:0]   rx_kind;
  logic [DSB_VSD_W-1:0]    rx_vendor;
  logic                    rx_pm_valid;
  logic                    retry_empty;
  logic                    dllp_pending;
  logic                    tlp_received;
  logic                    ecrc_gen_en;
  logic                    ecrc_chk_en;

  modport dev (
    input  send_sel,
    input  tx_kind,
    input  tx_vendor,
    output sent,
    output rx_kind,
    output rx_vendor,
    output rx_pm_valid,
    output retry_empty,
    output dllp_pending,
    output tlp_received,
    output ecrc_gen_en,
    output ecrc_chk_en
  );

  modport usr (
    output send_sel,
    output tx_kind,
    output tx_vendor,
    input  sent,
    input  rx_kind,
    input  rx_vendor,
    input  rx_pm_valid,
    input  retry_empty,
    input  dllp_pending,
    input  tlp_received,
    input  ecrc_gen_en,
    input  ecrc_chk_en
  );
endinterface

// ### hw/dsb_rbuf_count.sv
/*
  Occupancy counter for the transmit retry buffer.
  Assumes push and release come from same-clock link logic.
*/
`timescale 1ns/1ns
module dsb_rbuf_count #(
  parameter int unsigned DEPTH = dsb_pkg::DSB_RBUF_DEPTH
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic push_i,
  input  wire logic release_i,
  output logic      full_o,
  output logic      empty_o
);
  import dsb_pkg::*;

  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [CW-1:0] count_reg;
  logic          do_push;
  logic          do_rel;

  assign do_push = push_i && (count_reg != FULL_CNT);
  assign do_rel  = release_i && (count_reg != '0);

  //////////////////////////////////////////////////////////////////////
  // Count stored TLPs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg <= '0;
    end else if (do_push && !do_rel) begin
      count_reg <= count_reg + CW'(1);
    end else if (do_rel && !do_push) begin
      count_reg <= count_reg - CW'(1);
    end
  end

  assign full_o  = (count_reg == FULL_CNT);
  assign empty_o = (count_reg == '0); // R10
endmodule

// ### hw/dsb_usr_end.sv
/*
  User-logic end of the DLLP side-band port: turns one-shot requests into a
  held send-select and reports received events and status.
  Assumes request ports come from logic on the same clock.
*/
`timescale 1ns/1ns
module dsb_usr_end (
  input  wire logic                            clk_i,
  input  wire logic                            rstn_i,
  dsb_if.usr                                   sb,
  input  wire logic                            req_pm_i,
  input  wire logic                            req_vendor_i,
  input  wire logic [dsb_pkg::DSB_KIND_W-1:0]  pm_kind_i,
  input  wire logic [dsb_pkg::DSB_VSD_W-1:0]   vendor_data_i,
  output logic                                 busy_o,
  output logic                                 done_o,
  output logic                                 kind_error_o,
  output logic                                 rx_pm_o,
  output logic [dsb_pkg::DSB_KIND_W-1:0]       rx_kind_o,
  output logic [dsb_pkg::DSB_VSD_W-1:0]        rx_vendor_o,
  output logic                                 tlp_seen_o,
  output logic                                 link_idle_o,
  output logic                                 hdr_digest_o,
  output logic                                 crc_check_on_o
);
  import dsb_pkg::*;

  dsb_sel_t                sel_reg;
  logic [DSB_KIND_W-1:0]   kind_reg;
  logic [DSB_VSD_W-1:0]    data_reg;
  logic                    done_reg;
  logic                    kerr_reg;
  logic                    start;

  assign start = (sel_reg == DSB_SEL_NONE) && (req_pm_i || req_vendor_i);

  //////////////////////////////////////////////////////////////////////
  // Held request
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_reg  <= DSB_SEL_NONE;
      kind_reg <= DSB_KIND_RST;
      data_reg <= DSB_VSD_RST;
    end else if (start && req_pm_i && dsb_kind_legal(pm_kind_i)) begin
      sel_reg  <= DSB_SEL_PM; // R1
      kind_reg <= pm_kind_i; // R4
    end else if (start && !req_pm_i) begin
      sel_reg  <= DSB_SEL_VENDOR; // R2
      data_reg <= vendor_data_i; // R5
    end else if (sel_reg != DSB_SEL_NONE && sb.sent) begin
      sel_reg  <= DSB_SEL_NONE; // R17 R3
    end
  end

  assign sb.send_sel  = sel_reg;
  assign sb.tx_kind   = kind_reg;
  assign sb.tx_vendor = data_reg;

  //////////////////////////////////////////////////////////////////////
  // Completion and kind error pulses
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_reg <= 1'b0;
      kerr_reg <= 1'b0;
    end else begin
      done_reg <= (sel_reg != DSB_SEL_NONE) && sb.sent;
      kerr_reg <= start && req_pm_i && !dsb_kind_legal(pm_kind_i); // R4
    end
  end

  assign busy_o         = (sel_reg != DSB_SEL_NONE);
  assign done_o         = done_reg;
  assign kind_error_o   = kerr_reg;
  assign rx_pm_o        = sb.rx_pm_valid;
  assign rx_kind_o      = sb.rx_kind;
  assign rx_vendor_o    = sb.rx_vendor;
  assign tlp_seen_o     = sb.tlp_received;
  assign link_idle_o    = sb.retry_empty && !sb.dllp_pending;
  assign hdr_digest_o   = sb.ecrc_gen_en; // R15
  assign crc_check_on_o = sb.ecrc_chk_en;
endmodule

// ### verification/dsb_sb_monitor.sv
/*
  Checker on the side-band carrier signals between the user end and the device end.
  Assumes one clock for both ends and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module dsb_sb_monitor (
  input wire logic                           clk_i,
  input wire logic                           rstn_i,
  input wire dsb_pkg::dsb_sel_t              send_sel,
  input wire logic [dsb_pkg::DSB_KIND_W-1:0] tx_kind,
  input wire logic [dsb_pkg::DSB_VSD_W-1:0]  tx_vendor,
  input wire logic                           sent,
  input wire logic [dsb_pkg::DSB_KIND_W-1:0] rx_kind,
  input wire logic                           rx_pm_valid,
  input wire logic                           dllp_pending
);
  import dsb_pkg::*;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  ////////////////////////////////////////////////////////////////////////////
  // Request and completion steps
  sequence s_take;
    $rose(send_sel != DSB_SEL_NONE);
  endsequence
  sequence s_release;
    sent ##1 (send_sel == DSB_SEL_NONE);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  AST_SENT_PULSE: assert property (sent |=> !sent)
    else $error("sent wider than one cycle");
  AST_MIN_LAT: assert property (s_take |=> !sent)
    else $error("sent one cycle after request");
  AST_SENT_BOUND: assert property (s_take |-> ##[2:80] sent)
    else $error("request never sent");
  AST_PEND: assert property (s_take |-> ##[1:3] dllp_pending)
    else $error("taken request not shown pending");
  AST_SENT_SEL: assert property (sent |-> send_sel inside {DSB_SEL_PM, DSB_SEL_VENDOR})
    else $error("sent without a request");
  AST_RETURN: assert property (sent |-> s_release)
    else $error("select not returned to none");
  AST_HOLD: assert property ((send_sel != DSB_SEL_NONE) && !sent |=>
                             $stable(send_sel) && $stable(tx_kind) && $stable(tx_vendor))
    else $error("request changed before sent");
  AST_SEL_LEGAL: assert property (send_sel != DSB_SEL_UNUSED)
    else $error("unused select driven");
  AST_KIND_LEGAL: assert property (send_sel == DSB_SEL_PM |-> tx_kind inside {3'h0, 3'h1, 3'h3, 3'h4})
    else $error("illegal power kind requested");
  AST_RXKIND: assert property (!$stable(rx_kind) |-> rx_pm_valid)
    else $error("received kind changed without valid");
endmodule

// ### verification/dllp_sideband_and_ecrc_status_tb.sv
/*
  Self-checking bench: user end and device end joined by one carrier, plus a
  second device end without CRC support driven directly by the bench.
  Assumes the design files and package are compiled first.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module dllp_sideband_and_ecrc_status_tb;
  import dsb_pkg::*;
  localparam logic [11:0] KINDS = {3'h4, 3'h3, 3'h1, 3'h0};
  logic        clk_i, rstn_i, req_pm, req_vnd, ready, other_pend, rx_val, rx_pm, rx_tlp, push, rel;
  logic        cfg_gen, cfg_chk, valid, is_pm, full, valid2, busy, done, kerr, rxpm_o, tlp_o, idle_o;
  logic        dig_o, chk_o;
  logic [2:0]  pm_kind, rx_kind, kind, rxk_o;
  logic [23:0] vnd_data, rx_data, data, rxv_o;
  logic [31:0] seed, r;
  int          failures, check_count, cyc, n, i, j;

  dsb_if sb_if();
  dsb_if sb2();
  dsb_dev_end dsb_dev_end_i (.clk_i(clk_i), .rstn_i(rstn_i), .sb(sb_if), .link_dllp_valid_o(valid),
    .link_dllp_is_pm_o(is_pm), .link_dllp_kind_o(kind), .link_dllp_data_o(data), .link_dllp_ready_i(ready),
    .link_other_pend_i(other_pend), .link_rx_valid_i(rx_val), .link_rx_is_pm_i(rx_pm), .link_rx_kind_i(rx_kind),
    .link_rx_data_i(rx_data), .link_rx_tlp_i(rx_tlp), .rbuf_push_i(push), .rbuf_release_i(rel),
    .rbuf_full_o(full), .cfg_ecrc_gen_i(cfg_gen), .cfg_ecrc_chk_i(cfg_chk));
  dsb_dev_end #(.HAS_ECRC(1'b0)) dsb_dev_end_i2 (.clk_i(clk_i), .rstn_i(rstn_i), .sb(sb2),
    .link_dllp_valid_o(valid2), .link_dllp_is_pm_o(), .link_dllp_kind_o(), .link_dllp_data_o(),
    .link_dllp_ready_i(ready), .link_other_pend_i(other_pend), .link_rx_valid_i(rx_val), .link_rx_is_pm_i(rx_pm),
    .link_rx_kind_i(rx_kind), .link_rx_data_i(rx_data), .link_rx_tlp_i(rx_tlp), .rbuf_push_i(push),
    .rbuf_release_i(rel), .rbuf_full_o(), .cfg_ecrc_gen_i(cfg_gen), .cfg_ecrc_chk_i(cfg_chk));
  dsb_usr_end dsb_usr_end_i (.clk_i(clk_i), .rstn_i(rstn_i), .sb(sb_if), .req_pm_i(req_pm),
    .req_vendor_i(req_vnd), .pm_kind_i(pm_kind), .vendor_data_i(vnd_data), .busy_o(busy), .done_o(done),
    .kind_error_o(kerr), .rx_pm_o(rxpm_o), .rx_kind_o(rxk_o), .rx_vendor_o(rxv_o), .tlp_seen_o(tlp_o),
    .link_idle_o(idle_o), .hdr_digest_o(dig_o), .crc_check_on_o(chk_o));
  dsb_sb_monitor dsb_sb_monitor_i (.clk_i(clk_i), .rstn_i(rstn_i), .send_sel(sb_if.send_sel),
    .tx_kind(sb_if.tx_kind), .tx_vendor(sb_if.tx_vendor), .sent(sb_if.sent), .rx_kind(sb_if.rx_kind),
    .rx_pm_valid(sb_if.rx_pm_valid), .dllp_pending(sb_if.dllp_pending));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Link stalls one cycle in three
  always @(negedge clk_i) begin
    ready <= (cyc % 3) != 0;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task tick(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  task send(input logic pm, input logic [2:0] k, input logic [23:0] d);
    req_pm = pm;
    req_vnd = !pm;
    pm_kind = k;
    vnd_data = d;
    tick(1);
    req_pm = 1'b0;
    req_vnd = 1'b0;
    for (n = 0; n < 10 && valid !== 1'b1; n++) tick(1);
    `CHK("link_valid", 1'b1, valid)
    `CHK("link_is_pm", pm, is_pm)
    `CHK("link_word", pm ? {21'h0, k} : d, pm ? {21'h0, kind} : data)
    `CHK("pending", 1'b1, sb_if.dllp_pending)
    for (n = 0; n < 90 && done !== 1'b1; n++) tick(1);
    `CHK("done", 1'b1, done)
    `CHK("busy", 1'b0, busy)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h54;
    {req_pm, req_vnd, other_pend, rx_val, rx_pm, rx_tlp, push, rel} = '0;
    {pm_kind, rx_kind, vnd_data, rx_data} = '0;
    {cfg_gen, cfg_chk} = 2'h3;
    sb2.send_sel = DSB_SEL_NONE;
    sb2.tx_kind = 3'h0;
    sb2.tx_vendor = 24'h000000;
    rstn_i = 1'b0;
    tick(8);
    `CHK("gen_rst", 1'b0, sb_if.ecrc_gen_en)
    `CHK("empty_rst", 1'b1, sb_if.retry_empty)
    rstn_i = 1'b1;
    {cfg_gen, cfg_chk} = 2'h0;
    tick(2);
    for (i = 0; i < 12; i++) begin
      r = xs();
      send((i % 2) == 0, KINDS[3*((i/2)%4) +: 3], r[23:0]);
    end
    req_pm = 1'b1;
    pm_kind = 3'h2;
    tick(1);
    req_pm = 1'b0;
    for (n = 0; n < 5 && kerr !== 1'b1; n++) tick(1);
    `CHK("kind_err", 1'b1, kerr)
    `CHK("busy_bad", 1'b0, busy)
    for (j = 0; j < 4; j++) begin
      {rx_val, rx_pm, rx_kind} = {2'h3, KINDS[3*j +: 3]};
      tick(1);
      rx_val = 1'b0;
      `CHK("rx_valid", 1'b1, rxpm_o)
      `CHK("rx_kind", KINDS[3*j +: 3], rxk_o)
      tick(1);
      `CHK("rx_valid_end", 1'b0, rxpm_o)
    end
    r = xs();
    {rx_val, rx_pm, rx_kind, rx_data} = {2'h2, r[26:0]};
    tick(1);
    rx_val = 1'b0;
    `CHK("rx_vendor", r[23:0], rxv_o)
    `CHK("rx_vnd_pulse", 1'b0, rxpm_o)
    `CHK("rx_kind_hold", 3'h4, rxk_o)
    rx_tlp = 1'b1;
    tick(1);
    rx_tlp = 1'b0;
    `CHK("tlp", 1'b1, tlp_o)
    tick(1);
    `CHK("tlp_end", 1'b0, tlp_o)
    push = 1'b1;
    tick(1);
    push = 1'b0;
    `CHK("empty_push", 1'b0, sb_if.retry_empty)
    `CHK("idle_push", 1'b0, idle_o)
    rel = 1'b1;
    tick(1);
    rel = 1'b0;
    `CHK("empty_rel", 1'b1, sb_if.retry_empty)
    push = 1'b1;
    tick(DSB_RBUF_DEPTH + 1);
    push = 1'b0;
    `CHK("full", 1'b1, full)
    rel = 1'b1;
    tick(DSB_RBUF_DEPTH - 1);
    `CHK("empty_one", 1'b0, sb_if.retry_empty)
    tick(1);
    rel = 1'b0;
    `CHK("empty_all", 1'b1, sb_if.retry_empty)
    other_pend = 1'b1;
    tick(1);
    `CHK("pend_other", 1'b1, sb_if.dllp_pending)
    `CHK("idle_other", 1'b0, idle_o)
    other_pend = 1'b0;
    for (j = 0; j < 4; j++) begin
      {cfg_chk, cfg_gen} = j[1:0];
      tick(1);
      `CHK("gen_en", j[0], sb_if.ecrc_gen_en)
      `CHK("digest", j[0], dig_o)
      `CHK("chk_en", j[1], chk_o)
      `CHK("no_crc", 2'h0, {sb2.ecrc_gen_en, sb2.ecrc_chk_en})
    end
    sb2.send_sel = DSB_SEL_UNUSED;
    for (j = 0; j < 6; j++) begin
      tick(1);
      `CHK("unused_sel", 2'h0, {valid2, sb2.sent})
    end
    sb2.send_sel = DSB_SEL_NONE;
    tick(2);
    print_verdict();
  end
endmodule
